// ---- spt_consts.vh ----
// constants for the shared prescaler timer
`ifndef SPT_CONSTS_VH
`define SPT_CONSTS_VH
// register byte offsets
`define SPT_OFF_TIMER 8'h00
`define SPT_OFF_OPTION 8'h04
`define SPT_OFF_INTCTL 8'h08
`define SPT_OFF_CTRL 8'h0C
`define SPT_OFF_WDT 8'h10
// option register fields
`define SPT_OPT_PS_LO 0
`define SPT_OPT_PS_HI 2
`define SPT_OPT_ASSIGN 3
`define SPT_OPT_EDGE 4
`define SPT_OPT_SRC 5
`define SPT_OPT_RESET 8'hFF
// interrupt control fields
`define SPT_INT_FLAG 2
`define SPT_INT_EN 5
`define SPT_INT_RESET 8'h00
// control register fields (sleep, watchdog clear strobe)
`define SPT_CTL_SLEEP 0
`define SPT_CTL_WDCLR 1
// instruction cycle = 4 clocks
`define SPT_ICYC_DIV 2'h3
`define SPT_INHIBIT_CYC 2'h2
`define SPT_TIMER_MAX 8'hFF
`define SPT_WDT_MAX 8'hFF
`endif

// ---- spt_edge_det.v ----
// pin edge detector for the external count input
`include "spt_consts.vh"
module spt_edge_det (
	input wire clk,
	input wire rst,
	input wire pin,
	input wire falling_sel,
	output wire edge_pulse
);
	reg prev_q;
	always @(posedge clk) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= pin;
		end
	end
	// falling when select is one, rising otherwise
	assign edge_pulse = falling_sel ? (prev_q & ~pin) : (~prev_q & pin);
endmodule

// ---- spt_scaler.v ----
// shared 8-bit scaler with ratio tap selection
`include "spt_consts.vh"
module spt_scaler (
	input wire clk,
	input wire rst,
	input wire clear,
	input wire tick,
	input wire to_timer,
	input wire [2:0] ratio,
	output wire period_done
);
	reg [7:0] cnt_q;
	wire [7:0] cnt_d;
	wire [3:0] shift;
	wire [7:0] mask;
	// timer uses 2^(n+1), watchdog 2^n
	assign shift = to_timer ? ({1'b0, ratio} + 4'h1) : {1'b0, ratio};
	assign mask = (8'hFF >> (4'h8 - shift)) & ((shift == 4'h0) ? 8'h00 : 8'hFF);
	assign cnt_d = cnt_q + 8'h01;
	// completes when all bits under the mask are one before a tick
	assign period_done = tick & ((cnt_q & mask) == mask);
	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= 8'h00;
		end else if (clear) begin
			cnt_q <= 8'h00;
		end else if (tick) begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// ---- spt_timer.v ----
// shared prescaler timer: 8-bit timer/counter with shared scaler
// Functional notes
// - one 8-bit scaler, assigned to timer or watchdog, never both
// - scaler count is never readable or writable
// - assign bit and ratio field sit in option bits 3:0
// - assign zero: timer ratios 1:2 to 1:256
// - assign one: watchdog ratios 1:1 to 1:128
// - timer writes clear scaler while assigned to timer
// - watchdog clear resets watchdog and scaler when assigned to it
// - timer writes leave assignment and ratio untouched
// - assignment may change at any time
// - rollover FFh to 00h sets overflow flag, interrupt bit 2
// - interrupt request masked while enable bit 5 is zero
// - timer halts in sleep, overflow cannot wake
// - reset selects external pin, falling edge, no timer scaler
// - reset leaves timer count untouched
// - source zero counts instruction cycles, one counts pin edges
// - two instruction cycles of no increment after timer write
// - edge select zero rising, one falling
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`include "spt_consts.vh"
module spt_timer (
	input wire clk,
	input wire rst,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hsel,
	input wire hready,
	input wire timer_ext_clock_pin,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg timer_irq,
	output reg watchdog_timeout
);
	// ***********************************************
	// bus slave
	// ***********************************************
	reg wr_q;
	reg rd_q;
	reg [7:0] addr_q;
	wire take;
	assign take = hsel & hready & htrans[1];
	always @(posedge clk) begin
		if (rst) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q <= take & hwrite;
			rd_q <= take & ~hwrite;
			if (take) begin
				addr_q <= haddr[7:0];
			end
		end
	end
	wire wr_timer;
	wire wr_opt;
	wire wr_int;
	wire wr_ctl;
	assign wr_timer = wr_q & (addr_q == `SPT_OFF_TIMER);
	assign wr_opt = wr_q & (addr_q == `SPT_OFF_OPTION);
	assign wr_int = wr_q & (addr_q == `SPT_OFF_INTCTL);
	assign wr_ctl = wr_q & (addr_q == `SPT_OFF_CTRL);
	// ***********************************************
	// registers
	// ***********************************************
	reg [7:0] timer_count_reg_q;
	reg [7:0] option_q;
	reg [7:0] interrupt_control_reg_q;
	reg sleep_q;
	reg [7:0] wdt_q;
	reg [1:0] icyc_q;
	reg [1:0] inhibit_q;
	wire scaler_assign_select;
	wire [2:0] scale_ratio_select;
	wire timer_clock_source_select;
	wire timer_edge_select;
	wire watchdog_clear_instr;
	assign scaler_assign_select = option_q[`SPT_OPT_ASSIGN];
	assign scale_ratio_select = option_q[`SPT_OPT_PS_HI:`SPT_OPT_PS_LO];
	assign timer_clock_source_select = option_q[`SPT_OPT_SRC];
	assign timer_edge_select = option_q[`SPT_OPT_EDGE];
	assign watchdog_clear_instr = wr_ctl & hwdata[`SPT_CTL_WDCLR];
	// option register: reset gives pin source, falling edge, scaler to watchdog
	always @(posedge clk) begin
		if (rst) begin
			option_q <= `SPT_OPT_RESET;
		end else if (wr_opt) begin
			option_q <= hwdata[7:0];
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			sleep_q <= 1'b0;
		end else if (wr_ctl) begin
			sleep_q <= hwdata[`SPT_CTL_SLEEP];
		end
	end
	// ***********************************************
	// count sources
	// ***********************************************
	wire icyc_end;
	wire pin_edge;
	assign icyc_end = (icyc_q == `SPT_ICYC_DIV);
	always @(posedge clk) begin
		if (rst) begin
			icyc_q <= 2'h0;
		end else if (!sleep_q) begin
			icyc_q <= icyc_q + 2'h1;
		end
	end
	spt_edge_det u_edge (
		.clk(clk),
		.rst(rst),
		.pin(timer_ext_clock_pin),
		.falling_sel(timer_edge_select),
		.edge_pulse(pin_edge)
	);
	wire src_tick;
	// sleep freezes the timer path entirely
	assign src_tick = ~sleep_q & (timer_clock_source_select ? pin_edge
		: icyc_end);
	// watchdog runs from instruction cycles here; no own oscillator
	wire wdt_tick;
	assign wdt_tick = icyc_end & ~sleep_q;
	// ***********************************************
	// shared scaler
	// ***********************************************
	wire sc_clear;
	wire sc_tick;
	wire sc_done;
	// timer write leaves option bits alone, only count cleared
	assign sc_clear = (wr_timer & ~scaler_assign_select) |
		(watchdog_clear_instr & scaler_assign_select);
	assign sc_tick = scaler_assign_select ? wdt_tick : src_tick;
	spt_scaler u_scaler (
		.clk(clk),
		.rst(rst),
		.clear(sc_clear),
		.tick(sc_tick),
		.to_timer(~scaler_assign_select),
		.ratio(scale_ratio_select),
		.period_done(sc_done)
	);
	// ***********************************************
	// timer
	// ***********************************************
	wire timer_inc;
	wire timer_wrap;
	assign timer_inc = (scaler_assign_select ? src_tick : sc_done) &
		(inhibit_q == 2'h0);
	assign timer_wrap = timer_inc & (timer_count_reg_q == `SPT_TIMER_MAX);
	// write holds off increments for two instruction cycles
	always @(posedge clk) begin
		if (rst) begin
			inhibit_q <= 2'h0;
		end else if (wr_timer) begin
			inhibit_q <= `SPT_INHIBIT_CYC;
		end else if (icyc_end && inhibit_q != 2'h0) begin
			inhibit_q <= inhibit_q - 2'h1;
		end
	end
	// count is not reset, only loaded or incremented
	always @(posedge clk) begin
		if (wr_timer) begin
			timer_count_reg_q <= hwdata[7:0];
		end else if (timer_inc) begin
			timer_count_reg_q <= timer_count_reg_q + 8'h01;
		end
	end
	// flag set wins over software clear
	always @(posedge clk) begin
		if (rst) begin
			interrupt_control_reg_q <= `SPT_INT_RESET;
		end else begin
			if (wr_int) begin
				interrupt_control_reg_q <= hwdata[7:0];
			end
			if (timer_wrap) begin
				interrupt_control_reg_q[`SPT_INT_FLAG] <= 1'b1;
			end
		end
	end
	// ***********************************************
	// watchdog
	// ***********************************************
	wire wdt_inc;
	assign wdt_inc = scaler_assign_select ? sc_done : wdt_tick;
	always @(posedge clk) begin
		if (rst) begin
			wdt_q <= 8'h00;
			watchdog_timeout <= 1'b0;
		end else begin
			// a clear in the wrap cycle wins, so no stray timeout
			watchdog_timeout <= wdt_inc & (wdt_q == `SPT_WDT_MAX) &
				~watchdog_clear_instr;
			if (watchdog_clear_instr) begin
				wdt_q <= 8'h00;
			end else if (wdt_inc) begin
				wdt_q <= wdt_q + 8'h01;
			end
		end
	end
	// ***********************************************
	// outputs and read data
	// ***********************************************
	always @(posedge clk) begin
		if (rst) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= interrupt_control_reg_q[`SPT_INT_FLAG] &
				interrupt_control_reg_q[`SPT_INT_EN];
		end
	end
	// read data is registered at the address phase; scaler has no address
	always @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take && !hwrite) begin
				if (haddr[7:0] == `SPT_OFF_TIMER) begin
					hrdata <= {24'h000000, timer_count_reg_q};
				end else if (haddr[7:0] == `SPT_OFF_OPTION) begin
					hrdata <= {24'h000000, option_q};
				end else if (haddr[7:0] == `SPT_OFF_INTCTL) begin
					hrdata <= {24'h000000, interrupt_control_reg_q};
				end else if (haddr[7:0] == `SPT_OFF_CTRL) begin
					hrdata <= {31'h00000000, sleep_q};
				end else if (haddr[7:0] == `SPT_OFF_WDT) begin
					hrdata <= {24'h000000, wdt_q};
				end else begin
					hrdata <= 32'h00000000;
				end
			end
		end
	end
endmodule

// ---- spt_timer_properties.sv ----
// port checker for the shared prescaler timer
`include "spt_consts.vh"
module spt_timer_chk (
	input wire clk,
	input wire rst,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hsel,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire timer_irq,
	input wire watchdog_timeout
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	reg wr_q;
	reg rd_q;
	reg en_q;
	reg [7:0] a_q;
	sequence s_take;
		hsel && hready && htrans[1];
	endsequence
	sequence s_rd;
		s_take ##0 !hwrite;
	endsequence
	sequence s_wdclr;
		wr_q && a_q == `SPT_OFF_CTRL && hwdata[`SPT_CTL_WDCLR];
	endsequence
	// ****
	// shadow of the enable bit, rebuilt from bus writes
	// ****
	always @(posedge clk) begin
		wr_q <= !rst && hsel && hready && htrans[1] && hwrite;
		rd_q <= !rst && hsel && hready && htrans[1] && !hwrite;
		a_q <= haddr[7:0];
		if (rst)
			en_q <= 1'b0;
		else if (wr_q && a_q == `SPT_OFF_INTCTL)
			en_q <= hwdata[`SPT_INT_EN];
	end
	chk_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	chk_irq_masked: assert property (!en_q && !$past(en_q) |-> !timer_irq)
		else $error("irq while masked");
	chk_wdt_single: assert property (watchdog_timeout |=> !watchdog_timeout[*3])
		else $error("timeout pulse too long");
	chk_unmapped_zero: assert property (s_rd ##0 haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (s_rd |=> hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_read_hold: assert property (!rd_q |-> $stable(hrdata))
		else $error("read data moved");
	chk_clear_quiet: assert property (s_wdclr |-> ##2 !watchdog_timeout[*6])
		else $error("timeout after clear");
endmodule
bind spt_timer spt_timer_chk u_spt_timer_chk (.clk, .rst, .haddr, .htrans,
	.hwrite, .hwdata, .hsel, .hready, .hrdata, .hreadyout, .hresp,
	.timer_irq, .watchdog_timeout);

// ---- spt_pin_model.sv ----
// external count pin source on the far side of the timer
module spt_pin_model (
	input wire clk,
	input wire [7:0] pulses,
	input wire go,
	output reg pin,
	output wire busy
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [8:0] half_q = 9'h0;
	reg [1:0] ph_q = 2'h0;
	// each level stands four clocks so the sampled pin never misses one
	initial pin = 1'b0;
	assign busy = half_q != 9'h0;
	always @(posedge clk) begin
		ph_q <= ph_q + 2'h1;
		if (go && !busy)
			half_q <= {pulses, 1'b0};
		else if (busy && ph_q == 2'h3) begin
			pin <= !pin;
			half_q <= half_q - 9'h1;
		end
	end
endmodule

// ---- spt_timer_tb.sv ----
// self-checking bench for the shared prescaler timer
`include "spt_consts.vh"
module spt_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg hsel = 1'b0;
	reg go = 1'b0;
	reg [7:0] pulses = 8'h0;
	reg [31:0] r;
	reg [31:0] r1;
	wire [31:0] hrdata;
	wire hreadyout, hresp, timer_irq, watchdog_timeout, pin, busy;
	integer miscompares = 0;
	integer comparisons = 0;
	integer wd_seen = 0;
	integer c0;
	always #2.5 clk = ~clk;
	spt_timer u_spt_timer (.clk, .rst, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hsel, .hready(hreadyout),
		.timer_ext_clock_pin(pin), .hrdata, .hreadyout, .hresp,
		.timer_irq, .watchdog_timeout);
	spt_pin_model u_spt_pin_model (.clk, .pulses, .go, .pin, .busy);
	always @(posedge clk) begin
		if (watchdog_timeout)
			wd_seen <= wd_seen + 1;
	end
	// ****
	// bus and check helpers
	// ****
	task automatic xfer(input [7:0] a, input w, input [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsel <= 1'b1;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		r = hrdata;
	endtask
	task automatic ok(input c, input string m);
		comparisons++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("MISMATCH t=%0t %s r=%h", $time, m, r);
		end
	endtask
	task automatic rdc(input [7:0] a, input [31:0] e);
		xfer(a, 1'b0, 32'h0);
		ok(r === e, "read value");
	endtask
	task automatic pulse(input [7:0] n);
		pulses <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		while (busy) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask
	// ****
	// scenarios
	// ****
	task automatic test_reset;
		xfer(`SPT_OFF_TIMER, 1'b1, 32'hFFFFFF5A);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(`SPT_OFF_TIMER, 32'h5A);
		rdc(`SPT_OFF_OPTION, 32'hFF);
		rdc(`SPT_OFF_INTCTL, 32'h0);
		rdc(8'h14, 32'h0);
		$display("test reset done");
	endtask
	task automatic test_pin;
		xfer(`SPT_OFF_OPTION, 1'b1, 32'h28);
		xfer(`SPT_OFF_TIMER, 1'b1, 32'h0);
		repeat (12) @(posedge clk);
		pulse(8'h05);
		rdc(`SPT_OFF_TIMER, 32'h05);
		rdc(`SPT_OFF_OPTION, 32'h28);
		xfer(`SPT_OFF_OPTION, 1'b1, 32'h38);
		pulse(8'h03);
		rdc(`SPT_OFF_TIMER, 32'h08);
		$display("test pin done");
	endtask
	task automatic test_scale;
		for (int n = 0; n < 3; n++) begin
			xfer(`SPT_OFF_OPTION, 1'b1, n);
			xfer(`SPT_OFF_TIMER, 1'b1, 32'h0);
			repeat (80 << n) @(posedge clk);
			xfer(`SPT_OFF_TIMER, 1'b0, 32'h0);
			ok(r === 32'h09 || r === 32'h0A, "scaled count");
		end
		xfer(`SPT_OFF_CTRL, 1'b1, 32'h1);
		xfer(`SPT_OFF_TIMER, 1'b0, 32'h0);
		r1 = r;
		repeat (100) @(posedge clk);
		xfer(`SPT_OFF_TIMER, 1'b0, 32'h0);
		ok(r === r1, "count moved asleep");
		xfer(`SPT_OFF_CTRL, 1'b1, 32'h0);
		$display("test scale done");
	endtask
	task automatic test_ovf;
		xfer(`SPT_OFF_TIMER, 1'b1, 32'h0);
		xfer(`SPT_OFF_CTRL, 1'b1, 32'h2);
		xfer(`SPT_OFF_OPTION, 1'b1, 32'h08);
		xfer(`SPT_OFF_INTCTL, 1'b1, 32'h0);
		xfer(`SPT_OFF_TIMER, 1'b1, 32'hF0);
		repeat (100) @(posedge clk);
		rdc(`SPT_OFF_INTCTL, 32'h04);
		ok(timer_irq === 1'b0, "irq unmasked");
		xfer(`SPT_OFF_INTCTL, 1'b1, 32'h24);
		repeat (2) @(posedge clk);
		ok(timer_irq === 1'b1, "irq missing");
		xfer(`SPT_OFF_INTCTL, 1'b1, 32'h20);
		repeat (2) @(posedge clk);
		ok(timer_irq === 1'b0, "irq stuck");
		$display("test overflow done");
	endtask
	task automatic test_wdog;
		xfer(`SPT_OFF_CTRL, 1'b1, 32'h2);
		repeat (2) @(posedge clk);
		c0 = wd_seen;
		repeat (900) @(posedge clk);
		xfer(`SPT_OFF_CTRL, 1'b1, 32'h2);
		repeat (900) @(posedge clk);
		ok(wd_seen === c0, "early timeout");
		repeat (200) @(posedge clk);
		ok(wd_seen === c0 + 1, "no timeout");
		$display("test watchdog done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		test_reset;
		test_pin;
		test_scale;
		test_ovf;
		test_wdog;
		complete_run;
	end
	// tests need about 3000 clocks; over six times that is a hang
	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
endmodule
